// [include/ecm_pkg.sv]
// Purpose: Constants and types for the excitation current magnitude register block
// Assumes: Classic Wishbone slave with 32-bit data, one word per register
// Notes:   Offsets printed are indices; byte address is four times the index
//
// How it works
// - 8-bit magnitude register at index 0x0e, reset 0x00, both sources off.
// - Bits 7:4 are the read/write code for the second source.
// - Bits 3:0 are the read/write code for the first source, independent.
// - Code 0 is off; codes 1..10 give 50 to 3000 microamperes in order.
package ecm_pkg;

    localparam logic [7:0]  MAG_INDEX      = 8'h0e;
    localparam logic [31:0] MAG_ADDR       = {22'h000000, MAG_INDEX, 2'b00};
    localparam logic [31:0] STATUS_ADDR    = 32'h00000040;
    localparam logic [7:0]  MAG_RESET      = 8'h00;
    localparam int          SECOND_MSB     = 7;
    localparam int          SECOND_LSB     = 4;
    localparam int          FIRST_MSB      = 3;
    localparam int          FIRST_LSB      = 0;
    localparam logic [3:0]  CODE_OFF       = 4'h0;
    localparam logic [3:0]  CODE_MAX_VALID = 4'ha;
    localparam int          WB_ADDR_W      = 32;
    localparam int          WB_DATA_W      = 32;

    typedef struct packed {
        logic        enable;
        logic        reserved_code;
        logic [11:0] microamps;
    } ecm_setting_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } ecm_wb_req_s;

endpackage : ecm_pkg

// [core/ecm_decode.sv]
// Purpose: Decode one 4-bit magnitude code into a current setting
// Assumes: Pure combinational
// Notes:   Reserved codes decode as disabled
`timescale 1ns/10ps
module ecm_decode
(
    input  wire logic [3:0]           code,
    output ecm_pkg::ecm_setting_s     setting
);

    function automatic logic [11:0] ecm_microamps(input logic [3:0] c);
        case (c)
            4'h1:    ecm_microamps = 12'd50;
            4'h2:    ecm_microamps = 12'd100;
            4'h3:    ecm_microamps = 12'd250;
            4'h4:    ecm_microamps = 12'd500;
            4'h5:    ecm_microamps = 12'd750;
            4'h6:    ecm_microamps = 12'd1000;
            4'h7:    ecm_microamps = 12'd1500;
            4'h8:    ecm_microamps = 12'd2000;
            4'h9:    ecm_microamps = 12'd2500;
            4'ha:    ecm_microamps = 12'd3000;
            default: ecm_microamps = 12'd0;
        endcase
    endfunction : ecm_microamps

    always_comb
    begin
        setting.reserved_code = (code > ecm_pkg::CODE_MAX_VALID);
        setting.enable        = (code != ecm_pkg::CODE_OFF) && !setting.reserved_code;
        setting.microamps     = ecm_microamps(code);
    end

endmodule : ecm_decode

// [core/ecm_wb_slave.sv]
// Purpose: Classic Wishbone slave front end, one-cycle registered ack
// Assumes: Same clock as the register block
// Notes:   Ack is a pulse; a held request is acked again every other cycle
`timescale 1ns/10ps
module ecm_wb_slave
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  ecm_pkg::ecm_wb_req_s      req,
    output logic                      access,
    output logic                      ack_q
);

    logic ack_d;

    always_comb
    begin
        access = req.cyc && req.stb && !ack_q && ce;
        ack_d  = access;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack_q <= 1'b0;
        else if (ce)
            ack_q <= ack_d;
    end

endmodule : ecm_wb_slave

// [core/ecm_top.sv]
// Purpose: Excitation current magnitude register with decoded source settings
// Assumes: Classic Wishbone, 32-bit data, byte lane 0 carries the register
// Notes:   Unmapped reads return zero; writes there are dropped
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
module ecm_top
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             FIRST_SOURCE_ENABLE,
    output logic [11:0]      FIRST_SOURCE_MICROAMPS,
    output logic             SECOND_SOURCE_ENABLE,
    output logic [11:0]      SECOND_SOURCE_MICROAMPS
);

    ecm_pkg::ecm_wb_req_s  req;
    ecm_pkg::ecm_setting_s first_set;
    ecm_pkg::ecm_setting_s second_set;
    logic                  access;
    logic [7:0]            mag_q;
    logic [7:0]            mag_d;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic                  en1_q;
    logic                  en1_d;
    logic                  en2_q;
    logic                  en2_d;
    logic [11:0]           ua1_q;
    logic [11:0]           ua1_d;
    logic [11:0]           ua2_q;
    logic [11:0]           ua2_d;
    logic [1:0]            rsv_q;
    logic [1:0]            rsv_d;

    always_comb
    begin
        req.cyc = WB_CYC_I;
        req.stb = WB_STB_I;
        req.we  = WB_WE_I;
        req.sel = WB_SEL_I;
        req.adr = WB_ADR_I;
        req.dat = WB_DAT_I;
    end

    ecm_wb_slave u_wb
    (
        .clk    (CLK_SYS),
        .rst_n  (RST_N),
        .ce     (CE),
        .req    (req),
        .access (access),
        .ack_q  (WB_ACK_O)
    );

    ecm_decode u_dec_first
    (
        .code    (mag_q[ecm_pkg::FIRST_MSB:ecm_pkg::FIRST_LSB]),
        .setting (first_set)
    );

    ecm_decode u_dec_second
    (
        .code    (mag_q[ecm_pkg::SECOND_MSB:ecm_pkg::SECOND_LSB]),
        .setting (second_set)
    );

    // Register write and read mux
    always_comb
    begin
        mag_d   = mag_q;
        rdata_d = 32'h00000000;
        if (access && req.we && req.sel[0] && req.adr == ecm_pkg::MAG_ADDR)
            mag_d = req.dat[7:0];
        if (access && !req.we)
        begin
            if (req.adr == ecm_pkg::MAG_ADDR)
                rdata_d = {24'h000000, mag_q};
            else if (req.adr == ecm_pkg::STATUS_ADDR)
                rdata_d = {30'h00000000, rsv_q};
        end
    end

    // Decoded outputs registered
    always_comb
    begin
        en1_d = first_set.enable;
        en2_d = second_set.enable;
        ua1_d = first_set.microamps;
        ua2_d = second_set.microamps;
        rsv_d = {second_set.reserved_code, first_set.reserved_code};
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mag_q   <= ecm_pkg::MAG_RESET;
            rdata_q <= 32'h00000000;
            en1_q   <= 1'b0;
            en2_q   <= 1'b0;
            ua1_q   <= 12'h000;
            ua2_q   <= 12'h000;
            rsv_q   <= 2'b00;
        end
        else if (CE)
        begin
            mag_q   <= mag_d;
            rdata_q <= rdata_d;
            en1_q   <= en1_d;
            en2_q   <= en2_d;
            ua1_q   <= ua1_d;
            ua2_q   <= ua2_d;
            rsv_q   <= rsv_d;
        end
    end

    always_comb
    begin
        WB_DAT_O                = rdata_q;
        FIRST_SOURCE_ENABLE     = en1_q;
        FIRST_SOURCE_MICROAMPS  = ua1_q;
        SECOND_SOURCE_ENABLE    = en2_q;
        SECOND_SOURCE_MICROAMPS = ua2_q;
    end

endmodule : ecm_top

// [dv/ecm_chk.sv]
// Purpose: Port-level checks for the magnitude register block
// Assumes: Bound to ecm_top, one clock domain
// Notes:   Source outputs follow a write one edge after ack
`timescale 1ns/10ps
module ecm_chk
(
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        CE,
    input wire logic        WB_WE_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic        WB_ACK_O,
    input wire logic        FIRST_SOURCE_ENABLE,
    input wire logic [11:0] FIRST_SOURCE_MICROAMPS,
    input wire logic        SECOND_SOURCE_ENABLE,
    input wire logic [11:0] SECOND_SOURCE_MICROAMPS
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // Accepted write to the magnitude register
    sequence wr_mag;
        WB_ACK_O && WB_WE_I && WB_SEL_I[0] && CE && WB_ADR_I == ecm_pkg::MAG_ADDR;
    endsequence
    a_reset_off: assert property (
        $rose(RST_N) |-> !FIRST_SOURCE_ENABLE && !SECOND_SOURCE_ENABLE)
        else $error("source on after reset");
    a_first_enable: assert property (
        wr_mag |=> FIRST_SOURCE_ENABLE == ($past(WB_DAT_I[3:0]) inside {[4'h1:4'ha]}))
        else $error("first enable wrong");
    a_second_enable: assert property (
        wr_mag |=> SECOND_SOURCE_ENABLE == ($past(WB_DAT_I[7:4]) inside {[4'h1:4'ha]}))
        else $error("second enable wrong");
    a_enable_amps: assert property (
        FIRST_SOURCE_ENABLE == (FIRST_SOURCE_MICROAMPS != 12'h000)
        && SECOND_SOURCE_ENABLE == (SECOND_SOURCE_MICROAMPS != 12'h000))
        else $error("enable and current disagree");
    a_top_code: assert property (
        wr_mag and WB_DAT_I[3:0] == 4'ha |=> FIRST_SOURCE_MICROAMPS == 12'hbb8)
        else $error("top code current wrong");
endmodule : ecm_chk

// [dv/tb_top.sv]
// Purpose: Self-checking bench for the magnitude register block
// Assumes: Ack sampled at the rising edge, one idle cycle between cycles
// Notes:   Table rows use codes 0..10 only; reserved codes get hand tests
`timescale 1ns/10ps
module tb_top;
    logic                 CLK_SYS;
    logic                 RST_N;
    ecm_pkg::ecm_wb_req_s req;
    logic [31:0]          rd;
    logic [31:0]          q;
    logic                 ack;
    logic                 ce;
    logic                 f_en;
    logic                 s_en;
    logic [11:0]          f_ua;
    logic [11:0]          s_ua;
    int                   miscompares;
    int                   checked;
    typedef struct packed {
        logic [7:0]  code;
        logic [11:0] first_ua;
        logic [11:0] second_ua;
        logic        first_en;
        logic        second_en;
    } ecm_row_s;
    // Written byte beside the source settings it must give
    ecm_row_s             rows [11] = '{
        '{8'ha0, 12'h000, 12'hbb8, 1'b0, 1'b1}, '{8'h91, 12'h032, 12'h9c4, 1'b1, 1'b1},
        '{8'h82, 12'h064, 12'h7d0, 1'b1, 1'b1}, '{8'h73, 12'h0fa, 12'h5dc, 1'b1, 1'b1},
        '{8'h64, 12'h1f4, 12'h3e8, 1'b1, 1'b1}, '{8'h55, 12'h2ee, 12'h2ee, 1'b1, 1'b1},
        '{8'h46, 12'h3e8, 12'h1f4, 1'b1, 1'b1}, '{8'h37, 12'h5dc, 12'h0fa, 1'b1, 1'b1},
        '{8'h28, 12'h7d0, 12'h064, 1'b1, 1'b1}, '{8'h19, 12'h9c4, 12'h032, 1'b1, 1'b1},
        '{8'h0a, 12'hbb8, 12'h000, 1'b1, 1'b0}};
    ecm_top ecm_top_inst
    (
        .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(ce), .WB_CYC_I(req.cyc),
        .WB_STB_I(req.stb), .WB_WE_I(req.we), .WB_SEL_I(req.sel), .WB_ADR_I(req.adr),
        .WB_DAT_I(req.dat), .WB_DAT_O(rd), .WB_ACK_O(ack), .FIRST_SOURCE_ENABLE(f_en),
        .FIRST_SOURCE_MICROAMPS(f_ua), .SECOND_SOURCE_ENABLE(s_en),
        .SECOND_SOURCE_MICROAMPS(s_ua)
    );
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One classic bus cycle, entered at a rising edge
    task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'h1);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, w, s, a, {24'h000000, d}};
        do
        begin
            @(posedge CLK_SYS);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            summarize();
        end
        else
        begin
            q = rd;
            req <= '0;
            @(posedge CLK_SYS);
        end
    endtask : wb
    initial
    begin
        CLK_SYS = 1'b0;
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end
    initial
    begin
        RST_N = 1'b0;
        ce = 1'b1;
        req = '0;
        miscompares = 0;
        checked = 0;
        for (int r = 0; r < 2; r++)
        begin
            repeat (2) @(posedge CLK_SYS);
            RST_N <= 1'b1;
            @(posedge CLK_SYS);
            wb(1'b0, ecm_pkg::MAG_ADDR, 8'h00);
            chk(q, {24'h0, ecm_pkg::MAG_RESET});
            chk({30'h0, f_en, s_en}, 32'h0);
            $display("reset test done");
            for (int i = 0; i < 11; i++)
            begin
                wb(1'b1, ecm_pkg::MAG_ADDR, rows[i].code);
                wb(1'b0, ecm_pkg::MAG_ADDR, 8'h00);
                chk(q, {24'h0, rows[i].code});
                chk({20'h0, f_ua}, {20'h0, rows[i].first_ua});
                chk({20'h0, s_ua}, {20'h0, rows[i].second_ua});
                chk({30'h0, f_en, s_en},
                    {30'h0, rows[i].first_en, rows[i].second_en});
            end
            $display("code table done");
            wb(1'b1, ecm_pkg::MAG_ADDR, 8'hcb);
            wb(1'b0, ecm_pkg::MAG_ADDR, 8'h00);
            chk(q, 32'hcb);
            chk({6'h0, f_en, s_en, f_ua, s_ua}, 32'h0);
            wb(1'b0, ecm_pkg::STATUS_ADDR, 8'h00);
            chk(q, 32'h3);
            wb(1'b1, ecm_pkg::MAG_ADDR, 8'h5b);
            wb(1'b0, ecm_pkg::MAG_ADDR, 8'h00);
            chk(q, 32'h5b);
            chk({6'h0, f_en, s_en, f_ua, s_ua}, {6'h0, 2'b01, 12'h000, 12'h2ee});
            wb(1'b0, ecm_pkg::STATUS_ADDR, 8'h00);
            chk(q, 32'h1);
            $display("reserved code test done");
            wb(1'b1, 32'h3c, 8'hff);
            wb(1'b0, 32'h3c, 8'h00);
            chk(q, 32'h0);
            wb(1'b1, ecm_pkg::MAG_ADDR, 8'h11, 4'he);
            wb(1'b0, ecm_pkg::MAG_ADDR, 8'h00);
            chk(q, 32'h5b);
            $display("unmapped test done");
            ce <= 1'b0;
            req <= '{1'b1, 1'b1, 1'b1, 4'h1, ecm_pkg::MAG_ADDR, 32'h00000023};
            repeat (4) @(posedge CLK_SYS);
            chk({31'h0, ack}, 32'h0);
            ce <= 1'b1;
            wb(1'b1, ecm_pkg::MAG_ADDR, 8'h23);
            wb(1'b0, ecm_pkg::MAG_ADDR, 8'h00);
            chk(q, 32'h23);
            chk({8'h0, f_ua, s_ua}, {8'h0, 12'h0fa, 12'h064});
            $display("clock enable test done");
            RST_N <= 1'b0;
        end
        summarize();
    end
endmodule : tb_top
bind ecm_top ecm_chk ecm_chk_inst (.*);
